// ===== hw/readback_defines.svh
// constants for the serial readback path
`ifndef READBACK_DEFINES_SVH
`define READBACK_DEFINES_SVH

`define RB_CMD_W      29
`define RB_DATA_W     24
`define RB_PAD_W      5
`define RB_CNT_W      5
`define RB_CH_N       4
`define RB_MIN_BITS   5'h18
`define RB_CNT_MAX    5'h1f
`define RB_LVL_W      6
`define RB_PLD_W      22
`define RB_LVL_MSB    21
`define RB_LVL_LSB    16
`define RB_CLS_SYSCTL 2'h0
`define RB_CLS_CMP    2'h1
`define RB_CLS_RSVD   2'h2
`define RB_CLS_ALARM  2'h3
`define RB_SHREG_RST  29'h0000000
`define RB_DATA_RST   24'h000000
`define RB_PAD_ZERO   5'h00
`define RB_PIN_N      3
`define RB_PIN_SCLK   0
`define RB_PIN_SYNC   1
`define RB_PIN_SDI    2

`endif

// ===== hw/readback_pkg.sv
// types shared by the serial readback path
package readback_pkg;
`include "readback_defines.svh"

	// one command word as clocked in, msb first
	typedef struct packed {
		logic                   rd_wr;
		logic [`RB_CH_N-1:0]    chan_sel;
		logic                   register_class_hi;
		logic                   register_class_lo;
		logic [`RB_PLD_W-1:0]   payload;
	} cmd_word_t;

	// which register a read command selects
	typedef struct packed {
		logic                   global_sel;
		logic [1:0]             channel;
		logic [1:0]             reg_class;
		logic [`RB_LVL_W-1:0]   level_addr;
	} rd_sel_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_LOAD = 2'b10
	} fsm_t;

	typedef struct packed {
		logic                   meta;
		logic                   stable;
		logic                   prev;
	} sync_t;

	typedef struct packed {
		logic [`RB_CMD_W-1:0]   shreg;
		logic [`RB_CNT_W-1:0]   bitcnt;
		logic                   sdo;
		logic                   sdo_oe;
		fsm_t                   fsm;
		logic [`RB_DATA_W-1:0]  rd_buf;
		logic                   rd_req;
		rd_sel_t                rd_sel;
		logic                   cmd_valid;
		cmd_word_t              cmd;
		logic                   cmd_err;
	} state_t;

endpackage : readback_pkg

// ===== hw/pin_sync.sv
// two-flop synchroniser with edge pulses for one pin
`timescale 1ns/1ps
module pin_sync
	import readback_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);

	sync_t s_r;
	sync_t s_nxt;

	// meta feeds only the stable stage
	always_comb
	begin
		s_nxt        = s_r;
		s_nxt.meta   = pin_i;
		s_nxt.stable = s_r.meta;
		s_nxt.prev   = s_r.stable;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_r <= 3'h7;
		else
			s_r <= s_nxt;
	end

	// edges judged from settled stages only
	assign level_o = s_r.stable;
	assign rise_o  = s_r.stable & ~s_r.prev;
	assign fall_o  = ~s_r.stable & s_r.prev;

endmodule : pin_sync

// ===== hw/serial_register_readback.sv
// serial port readback: command capture, decode and shift-out
`timescale 1ns/1ps
module serial_register_readback
	import readback_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  sclk_i,
	input  wire logic                  sync_n_i,
	input  wire logic                  sdi_i,
	output logic                       sdo_o,
	output logic                       sdo_oe_o,
	output logic                       cmd_valid_o,
	output cmd_word_t                  cmd_o,
	output logic                       cmd_err_o,
	output logic                       rd_req_o,
	output rd_sel_t                    rd_sel_o,
	input  wire logic                  rd_valid_i,
	input  wire logic [`RB_DATA_W-1:0] rd_data_i
);

	state_t                 st_r;
	state_t                 st_nxt;
	logic [`RB_PIN_N-1:0]   pin_raw;
	logic [`RB_PIN_N-1:0]   pin_lvl;
	logic [`RB_PIN_N-1:0]   pin_rise;
	logic [`RB_PIN_N-1:0]   pin_fall;

	assign pin_raw[`RB_PIN_SCLK] = sclk_i;
	assign pin_raw[`RB_PIN_SYNC] = sync_n_i;
	assign pin_raw[`RB_PIN_SDI]  = sdi_i;

	// every pin takes the same two-flop delay, so sdi stays aligned to sclk
	generate
		for (genvar p = 0; p < `RB_PIN_N; p++)
		begin : g_pin
			pin_sync u_sync (
				.clk_i   (clk_i),
				.rst_n_i (rst_n_i),
				.pin_i   (pin_raw[p]),
				.level_o (pin_lvl[p]),
				.rise_o  (pin_rise[p]),
				.fall_o  (pin_fall[p])
			);
		end
	endgenerate

	logic                   in_frame;
	logic                   frame_start;
	logic                   frame_end;
	logic                   sclk_rise;
	cmd_word_t              word;
	logic [1:0]             cls;
	logic [`RB_CH_N-1:0]    ch;
	logic                   ch_none;
	logic                   ch_one;
	logic [1:0]             ch_idx;
	logic                   pld_zero;
	logic                   rd_ok;
	logic                   rd_bad;

	assign in_frame    = ~pin_lvl[`RB_PIN_SYNC];
	assign frame_start = pin_fall[`RB_PIN_SYNC];
	assign frame_end   = pin_rise[`RB_PIN_SYNC];
	assign sclk_rise   = pin_rise[`RB_PIN_SCLK];

	// field view of the captured word; after a short frame the top five
	// bits are the zeros left behind by the last load
	assign word     = cmd_word_t'(st_r.shreg);
	assign cls      = {word.register_class_hi, word.register_class_lo};
	assign ch       = word.chan_sel;
	assign ch_none  = (ch == 4'h0);
	assign ch_one   = (ch == 4'h1) | (ch == 4'h2) | (ch == 4'h4) | (ch == 4'h8);
	assign pld_zero = (word.payload == 22'h000000);

	// channel index from a one-hot select
	always_comb
	begin
		ch_idx = 2'h0;
		if (ch[3])
			ch_idx = 2'h3;
		else if (ch[2])
			ch_idx = 2'h2;
		else if (ch[1])
			ch_idx = 2'h1;
	end

	// read legality; reserved global class is answered by nothing
	always_comb
	begin
		rd_ok  = 1'b0;
		rd_bad = 1'b0;
		if (word.rd_wr)
		begin
			if (ch_none)
			begin
				if (cls == `RB_CLS_RSVD)
					rd_ok = 1'b0;
				else if (pld_zero)
					rd_ok = 1'b1;
				else
					rd_bad = 1'b1;
			end
			else if (ch_one)
			begin
				if (cls == `RB_CLS_SYSCTL)
				begin
					rd_ok  = pld_zero;
					rd_bad = ~pld_zero;
				end
				else
					rd_ok = 1'b1;
			end
			else
				rd_bad = 1'b1;
		end
	end

	// whole port state: one copy filled here, registered below
	always_comb
	begin
		st_nxt           = st_r;
		st_nxt.rd_req    = 1'b0;
		st_nxt.cmd_valid = 1'b0;
		st_nxt.cmd_err   = 1'b0;

		// a new frame restarts the edge count
		if (frame_start)
			st_nxt.bitcnt = 5'h00;

		// shift msb out, sdi in, on each rising sclk inside the frame
		if (in_frame && sclk_rise)
		begin
			st_nxt.shreg = {st_r.shreg[`RB_CMD_W-2:0], pin_lvl[`RB_PIN_SDI]};
			if (st_r.bitcnt != `RB_CNT_MAX)
				st_nxt.bitcnt = st_r.bitcnt + 5'h01;
		end

		// frames shorter than 24 edges are dropped as incomplete
		if (frame_end && (st_r.bitcnt >= `RB_MIN_BITS))
		begin
			st_nxt.cmd_valid = 1'b1;
			st_nxt.cmd       = word;
			st_nxt.cmd_err   = rd_bad;
			if (rd_ok)
			begin
				st_nxt.rd_req                = 1'b1;
				st_nxt.rd_sel.global_sel     = ch_none;
				st_nxt.rd_sel.channel        = ch_idx;
				st_nxt.rd_sel.reg_class      = cls;
				st_nxt.rd_sel.level_addr     = word.payload[`RB_LVL_MSB:`RB_LVL_LSB];
				st_nxt.fsm                   = ST_WAIT;
			end
		end

		// the answer may arrive at any time; it is parked until the line is idle
		unique case (st_r.fsm)
			ST_IDLE:
			begin
				st_nxt.rd_buf = st_r.rd_buf;
			end
			ST_WAIT:
			begin
				if (rd_valid_i && !st_nxt.rd_req)
				begin
					st_nxt.rd_buf = rd_data_i;
					st_nxt.fsm    = ST_LOAD;
				end
			end
			ST_LOAD:
			begin
				// loading mid-frame would corrupt the bits being shifted
				if (!in_frame && !frame_end)
				begin
					st_nxt.shreg = {st_r.rd_buf, `RB_PAD_ZERO};
					st_nxt.fsm   = ST_IDLE;
				end
			end
			default:
			begin
				st_nxt.fsm = ST_IDLE;
			end
		endcase

		// drive only inside the frame so several parts can share sdo
		st_nxt.sdo_oe = in_frame;
		st_nxt.sdo    = in_frame ? st_nxt.shreg[`RB_CMD_W-1] : 1'b0;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_r.shreg     <= `RB_SHREG_RST;
			st_r.bitcnt    <= 5'h00;
			st_r.sdo       <= 1'b0;
			st_r.sdo_oe    <= 1'b0;
			st_r.fsm       <= ST_IDLE;
			st_r.rd_buf    <= `RB_DATA_RST;
			st_r.rd_req    <= 1'b0;
			st_r.rd_sel    <= '0;
			st_r.cmd_valid <= 1'b0;
			st_r.cmd       <= '0;
			st_r.cmd_err   <= 1'b0;
		end
		else
			st_r <= st_nxt;
	end

	// all outputs straight from the state register
	assign sdo_o       = st_r.sdo;
	assign sdo_oe_o    = st_r.sdo_oe;
	assign cmd_valid_o = st_r.cmd_valid;
	assign cmd_o       = st_r.cmd;
	assign cmd_err_o   = st_r.cmd_err;
	assign rd_req_o    = st_r.rd_req;
	assign rd_sel_o    = st_r.rd_sel;

endmodule : serial_register_readback

// ===== sim/serial_register_readback_assertions.sv
// checker for the serial readback block ports
`timescale 1ns/1ps
module serial_register_readback_assertions
	import readback_pkg::*;
(
	input wire logic      clk_i,
	input wire logic      rst_n_i,
	input wire logic      sync_n_i,
	input wire logic      sdo_oe_o,
	input wire logic      cmd_valid_o,
	input wire cmd_word_t cmd_o,
	input wire logic      cmd_err_o,
	input wire logic      rd_req_o,
	input wire rd_sel_t   rd_sel_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_err; cmd_err_o |-> cmd_valid_o && !rd_req_o; endproperty
	a_err: assert property (p_err) else $error("bad error pulse");
	property p_req; rd_req_o |-> cmd_valid_o && cmd_o.rd_wr; endproperty
	a_req: assert property (p_req) else $error("bad read request");
	property p_pulse; cmd_valid_o |=> !cmd_valid_o; endproperty
	a_pulse: assert property (p_pulse) else $error("decode not a pulse");
	property p_idle; sync_n_i [*4] |-> !sdo_oe_o; endproperty
	a_idle: assert property (p_idle) else $error("output driven out of frame");
	property p_zero; rd_req_o && rd_sel_o.global_sel |-> cmd_o.payload == '0; endproperty
	a_zero: assert property (p_zero) else $error("global read with data");
	property p_glob;
		rd_req_o |-> rd_sel_o.global_sel == (cmd_o.chan_sel == 4'h0)
			&& rd_sel_o.reg_class == {cmd_o.register_class_hi, cmd_o.register_class_lo};
	endproperty
	a_glob: assert property (p_glob) else $error("bad register class");
	property p_rsvd;
		cmd_valid_o && cmd_o[28:22] == 7'h42 |-> !rd_req_o;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved read taken");
	property p_chan;
		rd_req_o && !rd_sel_o.global_sel |-> cmd_o.chan_sel == 4'h1 << rd_sel_o.channel;
	endproperty
	a_chan: assert property (p_chan) else $error("bad channel");
endmodule : serial_register_readback_assertions

bind serial_register_readback serial_register_readback_assertions u_chk (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .sync_n_i(sync_n_i), .sdo_oe_o(sdo_oe_o), .cmd_valid_o(cmd_valid_o),
	.cmd_o(cmd_o), .cmd_err_o(cmd_err_o), .rd_req_o(rd_req_o), .rd_sel_o(rd_sel_o));

// ===== sim/host_model.sv
// host controller model: drives serial frames, collects output bits
`timescale 1ns/1ps
module host_model
(
	output logic      sclk_o,
	output logic      sync_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	// link idle: clock parked low, frame inactive
	initial
	begin
		sclk_o   = 1'b0;
		sync_n_o = 1'b1;
		sdi_o    = 1'b0;
	end
	// n rising edges, msb of w first; non-blocking so a pin change that
	// lands on a clock edge cannot race the synchroniser
	task automatic xfer(input logic [28:0] w, input int n, output logic [28:0] rx);
		rx = '0;
		sync_n_o <= 1'b0;
		#413;
		for (int i = 0; i < n; i++)
		begin
			sdi_o <= w[28-i];
			#200;
			rx[28-i] = sdo_i;
			sclk_o <= 1'b1;
			#200;
			sclk_o <= 1'b0;
		end
		#200;
		sync_n_o <= 1'b1;
		sdi_o    <= ~sdi_o; // released line must not keep a stale bit
		#987;
	endtask : xfer
endmodule : host_model

// ===== sim/serial_register_readback_tb.sv
// self-checking bench for the serial readback block
`timescale 1ns/1ps
module serial_register_readback_tb
	import readback_pkg::*;
;
	logic        clk_i;
	logic        rst_n_i = 1'b0;
	logic        rd_valid_i = 1'b0;
	logic [23:0] rd_data_i = 24'h0;
	logic        sclk, sync_n, sdi, sdo_o, sdo_oe_o, cmd_valid_o, cmd_err_o, rd_req_o;
	cmd_word_t   cmd_o, last_cmd;
	rd_sel_t     rd_sel_o;
	int          n_val = 0, n_req = 0, n_err = 0, err_count = 0, samples_checked = 0;
	wire         sdo_line = sdo_oe_o ? sdo_o : 1'bz;
	serial_register_readback u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
		.sync_n_i(sync_n), .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
		.cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .cmd_err_o(cmd_err_o), .rd_req_o(rd_req_o),
		.rd_sel_o(rd_sel_o), .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i));
	host_model u_host (.sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi), .sdo_i(sdo_line));
	// register side: answers each request, data tagged with the selection
	always @(posedge clk_i)
	begin
		rd_valid_i <= rd_req_o;
		rd_data_i  <= {13'h1a5, rd_sel_o};
		if (cmd_valid_o === 1'b1)
		begin
			n_val    <= n_val + 1;
			n_req    <= n_req + int'(rd_req_o);
			n_err    <= n_err + int'(cmd_err_o);
			last_cmd <= cmd_o;
		end
	end
	task chk(input string name, input logic [28:0] exp, input logic [28:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// read command, then an n-edge frame that carries the word out
	task read_back(input logic [28:0] cmd, input rd_sel_t sel, input int n);
		int          r0;
		logic [28:0] rx;
		r0 = n_req;
		u_host.xfer(cmd, 29, rx);
		chk("rd_sel", {18'h0, sel}, {18'h0, rd_sel_o});
		chk("rd_req", 29'(r0 + 1), 29'(n_req));
		u_host.xfer((n == 24) ? 29'h1fffffe0 : 29'h0fffffff, n, rx);
		chk("sdo", {13'h1a5, sel, 5'h0}, rx);
		chk("sdo released", {28'h0, 1'bz}, {28'h0, sdo_line});
		if (n == 24)
			chk("short cmd", 29'h00ffffff, last_cmd);
	endtask : read_back
	// frame that must bring no read; errors and decodes counted
	task refuse(input logic [28:0] cmd, input int n, input int e);
		int          v0, r0, e0;
		logic [28:0] rx;
		v0 = n_val;
		r0 = n_req;
		e0 = n_err;
		u_host.xfer(cmd, n, rx);
		chk("decodes", 29'(v0 + int'(n >= 24)), 29'(n_val));
		chk("no read", 29'(r0), 29'(n_req));
		chk("errors", 29'(e0 + e), 29'(n_err));
		if (n >= 24)
			chk("cmd word", cmd, last_cmd);
	endtask : refuse
	task final_report;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// a hang ends in the report as a mismatch
	initial
	begin
		#2000000;
		err_count++;
		final_report();
	end
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		for (int c = 0; c < 4; c++)
			if (c != 2)
				read_back({7'h40 | 7'(c), 22'h0}, {3'h4, 2'(c), 6'h0}, 24);
		for (int h = 0; h < 4; h++)
			for (int c = 0; c < 4; c++)
				read_back({1'b1, 4'h1 << h, 2'(c), (c == 0) ? 6'h0 : 6'h2a, 16'h0},
					{1'b0, 2'(h), 2'(c), (c == 0) ? 6'h0 : 6'h2a}, 29);
		refuse(29'h1c000000, 29, 1);
		refuse(29'h11000001, 29, 1);
		refuse(29'h10c00001, 29, 1);
		refuse(29'h10800005, 29, 0);
		refuse(29'h11000000, 20, 0);
		final_report();
	end
endmodule : serial_register_readback_tb
